// *** sim/sccc_video_src.sv ***
// sccc_video_src: behavioural video source driving syncs and the external pins.
// assumes clk is the pixel clock; syncs change only just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module sccc_video_src
  import sccc_pkg::*;
#(
  parameter int LINE_LEN = 64,
  parameter int HS_LEN = 8,
  parameter int FRAME_LINES = 12,
  parameter int VS_LINES = 2,
  parameter int SEP_LINES = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic extCoast,
  input wire logic extClamp,
  output sccc_sync_in_t syncOut
);
  int pixQ;
  int lineQ;

  // vsync edges sit on hsync leading edges, as a filtered source would give
  always_ff @(posedge clk) begin
    if (reset || pixQ == LINE_LEN - 1) begin
      pixQ <= 0;
    end else begin
      pixQ <= pixQ + 1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lineQ <= 0;
    end else if (pixQ == LINE_LEN - 1) begin
      lineQ <= (lineQ == FRAME_LINES - 1) ? 0 : lineQ + 1;
    end
  end

  // separator pulse is shorter than the pin pulse so the two sources can be told apart
  assign syncOut = {pixQ < HS_LEN, lineQ < VS_LINES, lineQ < SEP_LINES, extCoast, extClamp};
endmodule
`default_nettype wire

// *** sim/tb_sync_coast_clamp_control.sv ***
// tb_sync_coast_clamp_control: self-checking bench for sccc_ctrl.
// assumes the source model's 64-cycle lines and 12-line frames.
`timescale 1ns/100ps
`default_nettype none
module tb_sync_coast_clamp_control;
  import sccc_pkg::*;
  localparam int FR = 12 * 64;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] extPin = 2'b00;
  sccc_sync_in_t syncIn;
  sccc_ctrl_out_t ctrlOut;
  int nMismatch = 0;
  int testsRun = 0;
  logic [7:0] rstTab [8] = '{8'h18, 8'h0A, 8'h00, 8'h00, 8'h20, 8'h08, 8'h14, 8'h58};

  always #2.5 clk = ~clk;

  sccc_ctrl DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .syncIn(syncIn), .ctrlOut(ctrlOut));
  sccc_video_src src (.clk(clk), .reset(reset), .extCoast(extPin[0]), .extClamp(extPin[1]),
    .syncOut(syncIn));

  task automatic summarize();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk(rd, {24'h0, exp});
    chk(32'(err), 32'h0);
  endtask

  // counts high cycles of one output over a whole frame, so phase does not matter
  task automatic count(input int sel, output int c);
    logic b;
    c = 0;
    repeat (FR) begin
      @(negedge clk);
      b = (sel == 0) ? ctrlOut.vsyncOut : (sel == 1) ? ctrlOut.coastOut : ctrlOut.clampOut;
      if (b === 1'b1) c++;
    end
  endtask

  task automatic frame(input int sel, input int exp);
    int c;
    repeat (2 * FR) @(negedge clk);
    count(sel, c);
    chk(c, exp);
  endtask

  task automatic pinPulse(input int sel, input logic act);
    int c;
    extPin[sel-1] <= ~act;
    repeat (2 * FR) @(posedge clk);
    fork
      count(sel, c);
      begin
        repeat (100) @(posedge clk);
        extPin[sel-1] <= act;
        repeat (6) @(posedge clk);
        extPin[sel-1] <= ~act;
      end
    join
    chk(c, 6);
  endtask

  task automatic clampGap(output int g, output int w);
    g = 0;
    w = 0;
    repeat (64) @(negedge clk);
    do @(negedge clk); while (syncIn.hsync !== 1'b1);
    do @(negedge clk); while (syncIn.hsync !== 1'b0);
    while (ctrlOut.clampOut !== 1'b1 && g < 200) begin
      @(negedge clk);
      g++;
    end
    while (ctrlOut.clampOut === 1'b1 && w < 300) begin
      @(negedge clk);
      w++;
    end
  endtask

  task automatic tReset();
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 8; i++)
      rdChk(8'(8'h14 + i), rstTab[i]);
    apb(1'b0, 8'h1C, 8'h00, rd, err);
    chk(rd, 32'h0); // unmapped place reads zero
    chk(32'(err), 32'h1); // unmapped place refused
    apb(1'b1, 8'h1F, 8'h00, rd, err);
    chk(32'(err), 32'h1); // status is read-only
    apb(1'b0, 8'h1F, 8'h00, rd, err);
    chk(32'(err), 32'h0); // status readable
    chk(ctrlOut.clampToMid, 3'b000);
    chk(ctrlOut.autoOffsetEn, 1'b0);
  endtask

  task automatic tRegs();
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h14 + i), ~rstTab[i]);
      rdChk(8'(8'h14 + i), ~rstTab[i]); // read-write access
      wr(8'(8'h14 + i), rstTab[i]);
    end
  endtask

  task automatic tMode();
    wr(8'h18, 8'h2E);
    repeat (3) @(negedge clk);
    chk(ctrlOut.clampToMid, 3'b111);
    wr(8'h18, 8'h24);
    repeat (3) @(negedge clk);
    chk(ctrlOut.clampToMid, 3'b010);
    wr(8'h18, 8'h20);
    wr(8'h1B, 8'h78);
    repeat (3) @(negedge clk);
    chk(ctrlOut.autoOffsetEn, 1'b1);
    wr(8'h1B, 8'h58);
  endtask

  task automatic tVsync();
    frame(0, 128);
    wr(8'h14, 8'h10);
    frame(0, FR - 128);
    wr(8'h14, 8'hD8);
    frame(0, 64);
    wr(8'h14, 8'h98);
    frame(0, 128);
    wr(8'h15, 8'h03);
    wr(8'h14, 8'h1E);
    frame(0, 192);
    wr(8'h14, 8'h18);
    frame(0, 128);
  endtask

  task automatic tCoast();
    frame(1, 128);
    wr(8'h17, 8'h02);
    frame(1, 256);
    wr(8'h16, 8'h01);
    frame(1, 320);
    wr(8'h14, 8'hD8);
    frame(1, 256);
    wr(8'h14, 8'h18);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h18, 8'hE0);
    pinPulse(1, 1'b1);
    wr(8'h18, 8'hC0);
    pinPulse(1, 1'b0);
    @(posedge clk);
    extPin[0] <= 1'b0;
    wr(8'h18, 8'h20);
  endtask

  task automatic tClamp();
    int g8;
    int w8;
    int g1;
    int w1;
    clampGap(g8, w8);
    // shortest legal settings, still inside the back porch
    wr(8'h19, 8'h01);
    wr(8'h1A, 8'h01);
    clampGap(g1, w1);
    chk(g8 - g1, 7);
    chk(w8, 20);
    chk(w1, 1);
    wr(8'h19, 8'h08);
    wr(8'h1A, 8'h14);
    wr(8'h18, 8'h30);
    wr(8'h1B, 8'hD8);
    pinPulse(2, 1'b1);
    wr(8'h1B, 8'h98);
    pinPulse(2, 1'b0);
    @(posedge clk);
    extPin[1] <= 1'b0;
    wr(8'h18, 8'h20);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    tReset();
    tRegs();
    tMode();
    tVsync();
    tCoast();
    tClamp();
    summarize();
  end
endmodule
`default_nettype wire

// *** verilog/sccc_ctrl.sv ***
// sccc_ctrl: vsync shaping, coast window and clamp control with an APB slave.
// assumes syncs arrive synchronous to clk, hsync active high, clk is the pixel clock.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - vsync output active low when polarity bit clear, high when set; default set.
// - filter enable aligns vsync edges to hsync leading edges.
// - duration enable clear keeps vsync width; set uses width register; default clear.
// - 8-bit width register, default 10, used only while duration enabled.
// - coast starts the lead-line count of hsync periods before vsync.
// - coast holds the trail-line count of hsync periods after vsync.
// - coast source bit: 0 vsync path, 1 external coast pin.
// - vsync coast source follows vsync source override and source bits.
// - coast polarity: auto when override clear, else bit 5 sets it.
// - clamp source bit: 0 internal timing, 1 external clamp pin.
// - per-channel bits clamp to ground when 0, midscale when 1.
// - internal clamp starts start-delay pixel periods after hsync trailing edge.
// - internal clamp lasts the pulse-width count; zero is unsupported.
// - external clamp selection ignores clamp delay and width.
// - clamp polarity: auto when override clear, else bit 6 sets it.
// - auto-offset bit: 0 manual offset, 1 automatic offset.
// - with override set, source bit picks vsync pin or separator.
module sccc_ctrl
  import sccc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LINE_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sccc_sync_in_t syncIn,
  output sccc_ctrl_out_t ctrlOut
);
  if (ADDR_W < 7 || LINE_W < 9) begin : g_bad_param
    $error("sccc_ctrl: ADDR_W must reach index 0x1F, LINE_W exceed the lead count");
  end

  function automatic logic [7:0] reset_value(input int i);
    case (i)
      0: reset_value = RST_VS_CTRL;
      1: reset_value = RST_VS_WIDTH;
      2: reset_value = RST_LEAD;
      3: reset_value = RST_TRAIL;
      4: reset_value = RST_CC_SEL;
      5: reset_value = RST_CLAMP_DLY;
      6: reset_value = RST_CLAMP_WID;
      default: reset_value = RST_CLAMP_POL;
    endcase
  endfunction

  // true when an input matches the level chosen as active
  function automatic logic is_active(input logic lvl, input logic polHigh);
    is_active = (lvl == polHigh);
  endfunction

  // register file
  logic [7:0] regs_q [0:NUM_REGS-1];
  logic [7:0] idx;
  logic [7:0] rdByte;
  logic [7:0] status;
  logic hit;
  logic isStatus;
  logic accessCyc;

  assign idx = 8'(paddr[ADDR_W-1:2]);
  assign accessCyc = psel && penable;

  always_comb begin
    hit = 1'b0;
    isStatus = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx >= IDX_VS_CTRL && idx <= IDX_CLAMP_POL) begin
      hit = 1'b1;
    end else if (idx == IDX_STATUS) begin
      isStatus = 1'b1;
    end
  end

  always_comb begin
    rdByte = 8'h00;
    if (hit) begin
      rdByte = regs_q[3'(idx - IDX_VS_CTRL)];
    end else if (isStatus) begin
      rdByte = status;
    end
  end

  assign pready = 1'b1;
  assign pslverr = accessCyc && !hit && !(isStatus && !pwrite);
  assign prdata = {24'h000000, rdByte};

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= reset_value(i);
      end
    end else if (accessCyc && pwrite && hit) begin
      regs_q[3'(idx - IDX_VS_CTRL)] <= pwdata[7:0];
    end
  end

  logic [7:0] vsCtrl, vsWidth, leadLines, trailLines, ccSel, clampDly, clampWid, clampPol;
  assign vsCtrl = regs_q[0];
  assign vsWidth = regs_q[1];
  assign leadLines = regs_q[2];
  assign trailLines = regs_q[3];
  assign ccSel = regs_q[4];
  assign clampDly = regs_q[5];
  assign clampWid = regs_q[6];
  assign clampPol = regs_q[7];

  logic external_black_level_select;
  logic black_level_pulse_polarity;
  assign external_black_level_select = ccSel[CS_EXT_CLAMP];
  assign black_level_pulse_polarity = clampPol[CP_POL];

  // polarity guesses for the auto modes
  logic vsSel, vsDetHigh, coastDetHigh, clampDetHigh;

  sccc_polarity_sense u_vs_sense (
    .clk(clk),
    .reset(reset),
    .level(vsSel),
    .activeHigh(vsDetHigh)
  );

  sccc_polarity_sense u_coast_sense (
    .clk(clk),
    .reset(reset),
    .level(syncIn.coastPin),
    .activeHigh(coastDetHigh)
  );

  sccc_polarity_sense u_clamp_sense (
    .clk(clk),
    .reset(reset),
    .level(syncIn.clampPin),
    .activeHigh(clampDetHigh)
  );

  // vsync source and input polarity; automatic choice takes the pin
  assign vsSel = (vsCtrl[VS_SRC_OVR] && vsCtrl[VS_SRC_SEP]) ? syncIn.vsyncSep
               : syncIn.vsyncPin;
  logic vsPolHigh;
  assign vsPolHigh = vsCtrl[VS_INPOL_OVR] ? vsCtrl[VS_INPOL] : vsDetHigh;

  logic hsPrev_q, hsRise, hsFall;
  logic vsAct_q, vsFilt_q, vsPrev_q;
  logic vsStage, vsStart, vsEnd;

  assign hsRise = syncIn.hsync && !hsPrev_q;
  assign hsFall = !syncIn.hsync && hsPrev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      hsPrev_q <= 1'b0;
      vsAct_q <= 1'b0;
      vsPrev_q <= 1'b0;
    end else begin
      hsPrev_q <= syncIn.hsync;
      vsAct_q <= is_active(vsSel, vsPolHigh);
      vsPrev_q <= vsStage;
    end
  end

  // filtered vsync only moves on hsync leading edges
  always_ff @(posedge clk) begin
    if (reset) begin
      vsFilt_q <= 1'b0;
    end else if (hsRise) begin
      vsFilt_q <= vsAct_q;
    end
  end

  assign vsStage = vsCtrl[VS_FILT_EN] ? vsFilt_q : vsAct_q;
  assign vsStart = vsStage && !vsPrev_q;
  assign vsEnd = !vsStage && vsPrev_q;

  // output width counted in hsync periods from the vsync start
  logic [7:0] durCnt_q;
  logic durActive_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      durCnt_q <= 8'h00;
      durActive_q <= 1'b0;
    end else if (vsStart) begin
      durCnt_q <= vsWidth;
      durActive_q <= (vsWidth != 8'h00);
    end else if (durActive_q && hsRise) begin
      durCnt_q <= durCnt_q - 8'h01;
      durActive_q <= (durCnt_q > 8'h01);
    end
  end

  logic vsShaped;
  assign vsShaped = vsCtrl[VS_DUR_EN] ? (durActive_q || vsStart) : vsStage;

  // line counting for the lead window: frame length measured between starts
  logic [LINE_W-1:0] lineCnt_q, frameLines_q;
  logic frameValid_q;
  localparam logic [LINE_W-1:0] LINE_MAX = {LINE_W{1'b1}};

  always_ff @(posedge clk) begin
    if (reset) begin
      lineCnt_q <= '0;
      frameLines_q <= '0;
      frameValid_q <= 1'b0;
    end else if (vsStart) begin
      lineCnt_q <= '0;
      frameLines_q <= lineCnt_q;
      frameValid_q <= (lineCnt_q != '0);
    end else if (hsRise && lineCnt_q != LINE_MAX) begin
      lineCnt_q <= lineCnt_q + 1'b1;
    end
  end

  // lead window opens when remaining lines fall to the lead count;
  // valid only while the filter enable stays unchanged, since vsStage follows the filter
  logic leadWin;
  logic [LINE_W:0] leadSum;
  assign leadSum = {1'b0, lineCnt_q} + (LINE_W+1)'(leadLines);
  assign leadWin = frameValid_q && leadLines != 8'h00 && !vsStage
                && leadSum >= {1'b0, frameLines_q};

  logic [7:0] trailCnt_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      trailCnt_q <= 8'h00;
    end else if (vsEnd) begin
      trailCnt_q <= trailLines;
    end else if (vsStart) begin
      trailCnt_q <= 8'h00;
    end else if (hsRise && trailCnt_q != 8'h00) begin
      trailCnt_q <= trailCnt_q - 8'h01;
    end
  end

  logic trailWin, intCoast, extCoast, coastPolHigh;
  assign trailWin = (trailCnt_q != 8'h00);
  assign intCoast = leadWin || vsStage || trailWin || (vsEnd && |trailLines);
  assign coastPolHigh = ccSel[CS_CPOL_OVR] ? ccSel[CS_CPOL] : coastDetHigh;
  assign extCoast = is_active(syncIn.coastPin, coastPolHigh);

  // internal clamp timing from the hsync trailing edge
  logic clampTimer;
  sccc_pulse_timer #(
    .W(8)
  ) u_clamp_timer (
    .clk(clk),
    .reset(reset),
    .start(hsFall && !external_black_level_select),
    .delay(clampDly),
    .width(clampWid),
    .active(clampTimer)
  );

  logic clampPolHigh, extClamp;
  assign clampPolHigh = clampPol[CP_POL_OVR] ? black_level_pulse_polarity
                      : clampDetHigh;
  assign extClamp = is_active(syncIn.clampPin, clampPolHigh);

  // all outputs registered so they are glitch-free toward the analog side
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlOut.vsyncOut <= ~RST_VS_CTRL[VS_OUTPOL];
    end else begin
      ctrlOut.vsyncOut <= vsCtrl[VS_OUTPOL] ? vsShaped : !vsShaped;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlOut.coastOut <= 1'b0;
    end else begin
      ctrlOut.coastOut <= ccSel[CS_COAST_PIN] ? extCoast : intCoast;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrlOut.clampOut <= 1'b0;
      ctrlOut.clampToMid <= 3'h0;
      ctrlOut.autoOffsetEn <= 1'b0;
    end else begin
      ctrlOut.clampOut <= external_black_level_select ? extClamp : clampTimer;
      ctrlOut.clampToMid <= ccSel[CS_RED_MID:CS_BLUE_MID];
      ctrlOut.autoOffsetEn <= clampPol[CP_AUTO_OFS];
    end
  end

  assign status = {vsDetHigh, coastDetHigh, clampDetHigh, frameValid_q,
                   vsStage, ctrlOut.vsyncOut, ctrlOut.coastOut, ctrlOut.clampOut};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_vs_pol;
    ctrlOut.vsyncOut == ($past(vsCtrl[VS_OUTPOL]) ~^ $past(vsShaped));
  endproperty

  property p_vs_filter;
    (vsCtrl[VS_FILT_EN] && $past(vsCtrl[VS_FILT_EN]) && vsStart) |-> $past(hsRise);
  endproperty

  property p_dur_off;
    (!vsCtrl[VS_DUR_EN] && $stable(vsCtrl)) |=>
      ctrlOut.vsyncOut == ($past(vsCtrl[VS_OUTPOL]) ~^ $past(vsStage));
  endproperty

  property p_dur_load;
    (vsStart && vsWidth != 8'h00) |=> durActive_q && durCnt_q == $past(vsWidth);
  endproperty

  property p_lead;
    (leadWin && !ccSel[CS_COAST_PIN] && $stable(ccSel)) |=> ctrlOut.coastOut;
  endproperty

  property p_trail;
    (vsEnd && trailLines != 8'h00) |=> trailWin [*1] ##0 trailCnt_q == $past(trailLines);
  endproperty

  property p_coast_src;
    ccSel[CS_COAST_PIN] |=> ctrlOut.coastOut == $past(extCoast);
  endproperty

  property p_coast_pol;
    (ccSel[CS_CPOL_OVR] && ccSel[CS_COAST_PIN]) |=>
      ctrlOut.coastOut == ($past(syncIn.coastPin) == $past(ccSel[CS_CPOL]));
  endproperty

  property p_clamp_ext;
    external_black_level_select |=> ctrlOut.clampOut == $past(extClamp);
  endproperty

  property p_clamp_mid;
    $changed(ccSel) |=> ctrlOut.clampToMid == $past(ccSel[3:1]);
  endproperty

  property p_auto_ofs;
    ctrlOut.autoOffsetEn == $past(clampPol[CP_AUTO_OFS]);
  endproperty

  property p_vs_src;
    (vsCtrl[VS_SRC_OVR] && vsCtrl[VS_SRC_SEP]) |-> vsSel == syncIn.vsyncSep;
  endproperty

  a_vs_pol: assert property (p_vs_pol) else $error("vsync output polarity wrong");
  a_vs_filter: assert property (p_vs_filter) else $error("filtered vsync off hsync");
  a_dur_off: assert property (p_dur_off) else $error("vsync width altered");
  a_dur_load: assert property (p_dur_load) else $error("vsync width not loaded");
  a_lead: assert property (p_lead) else $error("lead coast missing");
  a_trail: assert property (p_trail) else $error("trail coast not loaded");
  a_coast_src: assert property (p_coast_src) else $error("coast source wrong");
  a_coast_pol: assert property (p_coast_pol) else $error("coast polarity wrong");
  a_clamp_ext: assert property (p_clamp_ext) else $error("external clamp wrong");
  a_clamp_mid: assert property (p_clamp_mid) else $error("clamp level select wrong");
  a_auto_ofs: assert property (p_auto_ofs) else $error("auto offset mode wrong");
  a_vs_src: assert property (p_vs_src) else $error("vsync source wrong");

  c_clamp_int: cover property (!external_black_level_select ##1 $rose(ctrlOut.clampOut));
  c_lead: cover property (leadWin ##1 vsStart);
  c_trail: cover property ($fell(trailWin) && !vsStage);
  c_dur: cover property ($fell(durActive_q) && vsStage);
endmodule
`default_nettype wire

// *** verilog/sccc_pkg.sv ***
// sccc_pkg: constants and carrier types of the sync, coast and clamp control block.
// assumes one 200 MHz clock that also serves as the pixel period reference.
package sccc_pkg;
  localparam int CLK_MHZ = 200;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_VS_CTRL = 8'h14;
  localparam logic [7:0] IDX_VS_WIDTH = 8'h15;
  localparam logic [7:0] IDX_LEAD = 8'h16;
  localparam logic [7:0] IDX_TRAIL = 8'h17;
  localparam logic [7:0] IDX_CC_SEL = 8'h18;
  localparam logic [7:0] IDX_CLAMP_DLY = 8'h19;
  localparam logic [7:0] IDX_CLAMP_WID = 8'h1A;
  localparam logic [7:0] IDX_CLAMP_POL = 8'h1B;
  localparam logic [7:0] IDX_STATUS = 8'h1F;
  localparam int NUM_REGS = 8;
  localparam logic [7:0] RST_VS_CTRL = 8'h18;
  localparam logic [7:0] RST_VS_WIDTH = 8'h0A;
  localparam logic [7:0] RST_LEAD = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;
  localparam logic [7:0] RST_CC_SEL = 8'h20;
  localparam logic [7:0] RST_CLAMP_DLY = 8'h08;
  localparam logic [7:0] RST_CLAMP_WID = 8'h14;
  localparam logic [7:0] RST_CLAMP_POL = 8'h58;
  // vsync_shaping_control fields
  localparam int VS_SRC_OVR = 7;
  localparam int VS_SRC_SEP = 6;
  localparam int VS_INPOL_OVR = 5;
  localparam int VS_INPOL = 4;
  localparam int VS_OUTPOL = 3;
  localparam int VS_FILT_EN = 2;
  localparam int VS_DUR_EN = 1;
  // coast_clamp_select fields
  localparam int CS_COAST_PIN = 7;
  localparam int CS_CPOL_OVR = 6;
  localparam int CS_CPOL = 5;
  localparam int CS_EXT_CLAMP = 4;
  localparam int CS_RED_MID = 3;
  localparam int CS_BLUE_MID = 1;
  // clamp_polarity_offset_mode fields
  localparam int CP_POL_OVR = 7;
  localparam int CP_POL = 6;
  localparam int CP_AUTO_OFS = 5;
  localparam int POL_SENSE_W = 10;

  typedef struct packed {
    logic hsync;
    logic vsyncPin;
    logic vsyncSep;
    logic coastPin;
    logic clampPin;
  } sccc_sync_in_t;

  typedef struct packed {
    logic vsyncOut;
    logic coastOut;
    logic clampOut;
    logic [2:0] clampToMid;
    logic autoOffsetEn;
  } sccc_ctrl_out_t;
endpackage

// *** verilog/sccc_polarity_sense.sv ***
// sccc_polarity_sense: guesses the active level of a sync-like input.
// assumes the input is synchronous and idles far longer than it is active.
`timescale 1ns/100ps
`default_nettype none
module sccc_polarity_sense
  import sccc_pkg::*;
#(
  parameter int CNT_W = POL_SENSE_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  output logic activeHigh
);
  if (CNT_W < 2) begin : g_bad_width
    $error("sccc_polarity_sense: CNT_W too small");
  end

  logic [CNT_W-1:0] bal_q;
  localparam logic [CNT_W-1:0] MID = {1'b1, {(CNT_W-1){1'b0}}};
  localparam logic [CNT_W-1:0] TOP = {CNT_W{1'b1}};

  // low time pushes up: a mostly-low line is active high
  always_ff @(posedge clk) begin
    if (reset) begin
      bal_q <= MID;
    end else if (!level && bal_q != TOP) begin
      bal_q <= bal_q + 1'b1;
    end else if (level && bal_q != '0) begin
      bal_q <= bal_q - 1'b1;
    end
  end

  assign activeHigh = bal_q[CNT_W-1];
endmodule
`default_nettype wire

// *** verilog/sccc_pulse_timer.sv ***
// sccc_pulse_timer: one pulse of programmed width after a programmed delay.
// assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/100ps
`default_nettype none
module sccc_pulse_timer
  import sccc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [W-1:0] delay,
  input wire logic [W-1:0] width,
  output logic active
);
  if (W < 1) begin : g_bad_width
    $error("sccc_pulse_timer: W must be positive");
  end

  typedef enum logic [1:0] {TM_IDLE, TM_WAIT, TM_ON} sccc_tm_state_t;
  sccc_tm_state_t state_q;
  logic [W-1:0] cnt_q;

  // zero delay is unsupported; it behaves as one
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= TM_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        TM_IDLE: begin
          if (start && width != '0) begin
            state_q <= TM_WAIT;
            cnt_q <= (delay == '0) ? W'(1) : delay;
          end
        end
        TM_WAIT: begin
          if (cnt_q <= W'(1)) begin
            state_q <= TM_ON;
            cnt_q <= width;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          if (cnt_q <= W'(1)) begin
            state_q <= TM_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  assign active = (state_q == TM_ON);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_on_width;
    $rose(active) |-> cnt_q == $past(width);
  endproperty
  a_on_width: assert property (p_on_width) else $error("clamp width not loaded");

  property p_wait_then_on;
    (state_q == TM_WAIT && cnt_q == W'(1)) |=> active;
  endproperty
  a_wait_then_on: assert property (p_wait_then_on) else $error("clamp late");
endmodule
`default_nettype wire
